// [design/tx_pcf_pkg.sv]
// Purpose: Shared constants and types of the transmit phase compensation FIFO
// Assumes: 32-bit AXI4-Lite register access, one system clock
// Notes:   Register layout, reset values and bus answers live here
package tx_pcf_pkg;

    // Data path shape
    localparam int DATA_W     = 32;
    localparam int CTRL_W     = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int LVL_W      = $clog2(FIFO_DEPTH) + 1;
    localparam int ADDR_W     = 5;
    localparam int DIV_W      = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 5'h00;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] DIV_OFS    = 5'h08;
    localparam logic [ADDR_W-1:0] COUNT_OFS  = 5'h0C;

    // Reset values and thresholds
    localparam logic [31:0]      CTRL_RESET  = 32'h0000_0000;
    localparam logic [DIV_W-1:0] DIV_RESET   = 8'h04;
    localparam logic [LVL_W-1:0] START_LEVEL = LVL_W'(FIFO_DEPTH / 2);

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        BOND_NONE,
        BOND_X4,
        BOND_X8
    } bond_mode_t;

    // Control register
    typedef struct packed {
        logic [25:0] rsvd;
        bond_mode_t  bond;
        logic        group_follow;
        logic        byte_ser;
        logic        user_wclk;
        logic        enable;
    } ctrl_t;

    // Status register
    typedef struct packed {
        logic [23-LVL_W:0] rsvd_hi;
        logic [LVL_W-1:0]  level;
        logic [4:0]        rsvd_lo;
        logic              primed;
        logic              underrun;
        logic              overflow;
    } status_t;

    // One transmit word: control bits above data
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [DATA_W-1:0] data;
    } tx_word_t;

    localparam int WORD_W = $bits(tx_word_t);

endpackage

// [design/tx_pcf_fifo.sv]
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock; push and pop may share a cycle
// Notes:   Width and depth shape the storage array and pointers
module tx_pcf_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       reset_n,
    // Fill side
    input  wire logic                       in_valid,
    input  wire logic [WIDTH-1:0]           in_data,
    output logic                            in_ready,
    // Drain side
    output logic                            out_valid,
    output logic [WIDTH-1:0]                out_data,
    input  wire logic                       out_ready,
    // Fill level
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign level     = count;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule

// [design/tx_phase_comp_fifo.sv]
// Purpose: Transmit phase compensation FIFO with selectable write and read clocking
// Assumes: Clock pins are slow against sys_clk; each rising edge becomes a one-cycle tick
// Notes:   Registers over AXI4-Lite; write and read ticks must run at one rate
// How it works
// - The FIFO takes words on the write tick and gives them out on the read tick, absorbing phase.
// - With the user write clock enabled, its pin alone paces the FIFO write side.
// - Any rate difference shows as overflow or underrun, and the data then goes bad.
// - Unbonded without byte serializer, reads follow the local divider, also sent out as the channel clock.
// - With the byte serializer, reads take every second tick of the selected parallel clock.
// - In four-lane bonding, reads follow clock_unit_zero of this block, sent out as the bonded clock.
// - In eight-lane bonding, reads follow clock_unit_zero of the master block.
// - Without the user clock, writes follow the group lead clock when unbonded with group_follow set, else the read tick.
module tx_phase_comp_fifo (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    // AXI4-Lite write
    input  wire logic [4:0]                 s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [4:0]                 s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Fabric transmit words
    input  wire tx_pcf_pkg::tx_word_t       tx_word,
    input  wire logic                       tx_valid,
    output logic                            tx_ready,
    // Clock pins
    input  wire logic                       user_wclk,
    input  wire logic                       group_lead_clk,
    input  wire logic                       cu0_local_clk,
    input  wire logic                       cu0_master_clk,
    // Coding sublayer side
    output tx_pcf_pkg::tx_word_t            pcs_word,
    output logic                            pcs_valid,
    output logic                            chan_par_clk_out,
    output logic                            bonded_clk_out,
    output logic                            overflow_flag,
    output logic                            underrun_flag
);
    localparam int NPIN = 4;

    // Pin synchronisers
    logic [NPIN-1:0] pin_sync1;
    logic [NPIN-1:0] pin_sync2;
    logic [NPIN-1:0] pin_dly;
    logic [NPIN-1:0] pin_edge;

    // Registers and bus state
    tx_pcf_pkg::ctrl_t            ctrl, next_ctrl;
    logic [tx_pcf_pkg::DIV_W-1:0] div_ratio, next_div_ratio;
    logic [31:0]                  word_count, next_word_count;
    logic                         aw_held, next_aw_held;
    logic                         w_held, next_w_held;
    logic [4:0]                   aw_addr, next_aw_addr;
    logic [31:0]                  w_data, next_w_data;
    logic [3:0]                   w_strb, next_w_strb;
    logic                         next_awready, next_wready, next_bvalid, next_arready;
    logic                         next_rvalid;
    logic [1:0]                   next_bresp, next_rresp;
    logic [31:0]                  next_rdata;
    logic                         ovf_clr, udr_clr;

    // Data path state
    logic [tx_pcf_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
    logic                         par_tick, next_par_tick;
    logic                         half, next_half;
    logic                         hold_valid, next_hold_valid;
    tx_pcf_pkg::tx_word_t         hold_word, next_hold_word;
    logic                         next_tx_ready;
    logic                         primed, next_primed;
    logic                         next_overflow, next_underrun;
    tx_pcf_pkg::tx_word_t         next_pcs_word;
    logic                         next_pcs_valid, next_bonded_clk;
    logic                         sel_tick, rd_tick, wr_tick, auto_wr_tick;
    logic                         push, pop, ovf_event, udr_event;
    logic                         fifo_in_ready, fifo_out_valid;
    tx_pcf_pkg::tx_word_t         fifo_out_data;
    logic [tx_pcf_pkg::LVL_W-1:0] fifo_level;
    tx_pcf_pkg::status_t          status;

    function automatic logic is_mapped(input logic [4:0] addr);
        return (addr[4] == 1'b0);
    endfunction

    // Bond code 3 behaves as unbonded
    function automatic logic is_bonded(input tx_pcf_pkg::bond_mode_t mode);
        return (mode == tx_pcf_pkg::BOND_X4) || (mode == tx_pcf_pkg::BOND_X8);
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Two flops before any use, third for edge detection
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            pin_sync1 <= '0;
            pin_sync2 <= '0;
            pin_dly   <= '0;
        end else begin
            pin_sync1 <= {cu0_master_clk, cu0_local_clk, group_lead_clk, user_wclk};
            pin_sync2 <= pin_sync1;
            pin_dly   <= pin_sync2;
        end
    end

    generate
        for (genvar g = 0; g < NPIN; g++) begin : g_edge
            assign pin_edge[g] = pin_sync2[g] && !pin_dly[g];
        end
    endgenerate

    // Clock selection
    always_comb begin
        case (ctrl.bond)
            tx_pcf_pkg::BOND_NONE: sel_tick = par_tick;
            tx_pcf_pkg::BOND_X4:   sel_tick = pin_edge[2];
            tx_pcf_pkg::BOND_X8:   sel_tick = pin_edge[3];
            default:               sel_tick = par_tick;
        endcase
    end

    assign rd_tick      = ctrl.enable && sel_tick && (!ctrl.byte_ser || half);
    assign auto_wr_tick = (!is_bonded(ctrl.bond) && ctrl.group_follow)
                          ? pin_edge[1] : rd_tick;
    assign wr_tick      = ctrl.enable && (ctrl.user_wclk ? pin_edge[0] : auto_wr_tick);
    assign push         = wr_tick && hold_valid && fifo_in_ready;
    assign pop          = rd_tick && primed && fifo_out_valid;
    assign ovf_event    = wr_tick && hold_valid && !fifo_in_ready;
    assign udr_event    = rd_tick && primed && !fifo_out_valid;

    tx_pcf_fifo #(
        .WIDTH (tx_pcf_pkg::WORD_W),
        .DEPTH (tx_pcf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (sys_clk),
        .reset_n   (reset_n),
        .in_valid  (push),
        .in_data   (hold_word),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (pop),
        .level     (fifo_level)
    );

    // Data path next state
    always_comb begin
        next_div_cnt    = div_cnt;
        next_par_tick   = 1'b0;
        next_half       = half;
        next_hold_valid = hold_valid;
        next_hold_word  = hold_word;
        next_primed     = primed;
        next_pcs_word   = pcs_word;
        next_pcs_valid  = pop;
        next_bonded_clk = is_bonded(ctrl.bond) && sel_tick;
        next_word_count = pop ? word_count + 32'h1 : word_count;
        if (!ctrl.enable) begin
            next_div_cnt = '0;
            next_half    = 1'b0;
            next_primed  = 1'b0;
        end else begin
            if ({1'b0, div_cnt} + 9'h001 >= {1'b0, div_ratio}) begin
                next_div_cnt  = '0;
                next_par_tick = 1'b1;
            end else begin
                next_div_cnt = div_cnt + 1'b1;
            end
            if (sel_tick) begin
                next_half = !half;
            end
            if (fifo_level >= tx_pcf_pkg::START_LEVEL) begin
                next_primed = 1'b1;
            end
        end
        if (push || ovf_event) begin
            next_hold_valid = 1'b0;
        end
        if (tx_valid && tx_ready) begin
            next_hold_valid = 1'b1;
            next_hold_word  = tx_word;
        end
        if (pop) begin
            next_pcs_word = fifo_out_data;
        end
        next_tx_ready = ctrl.enable && !next_hold_valid;
        next_overflow = ovf_event || (overflow_flag && !ovf_clr);
        next_underrun = udr_event || (underrun_flag && !udr_clr);
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            div_cnt          <= '0;
            par_tick         <= 1'b0;
            half             <= 1'b0;
            hold_valid       <= 1'b0;
            hold_word        <= '0;
            primed           <= 1'b0;
            pcs_word         <= '0;
            pcs_valid        <= 1'b0;
            bonded_clk_out   <= 1'b0;
            chan_par_clk_out <= 1'b0;
            tx_ready         <= 1'b0;
            overflow_flag    <= 1'b0;
            underrun_flag    <= 1'b0;
            word_count       <= '0;
        end else begin
            div_cnt          <= next_div_cnt;
            par_tick         <= next_par_tick;
            half             <= next_half;
            hold_valid       <= next_hold_valid;
            hold_word        <= next_hold_word;
            primed           <= next_primed;
            pcs_word         <= next_pcs_word;
            pcs_valid        <= next_pcs_valid;
            bonded_clk_out   <= next_bonded_clk;
            chan_par_clk_out <= next_par_tick;
            tx_ready         <= next_tx_ready;
            overflow_flag    <= next_overflow;
            underrun_flag    <= next_underrun;
            word_count       <= next_word_count;
        end
    end

    // Register file and bus slave
    always_comb begin
        status          = '0;
        status.level    = fifo_level;
        status.primed   = primed;
        status.underrun = underrun_flag;
        status.overflow = overflow_flag;
        next_ctrl       = ctrl;
        next_div_ratio  = div_ratio;
        ovf_clr         = 1'b0;
        udr_clr         = 1'b0;
        next_aw_held    = aw_held;
        next_aw_addr    = aw_addr;
        next_w_held     = w_held;
        next_w_data     = w_data;
        next_w_strb     = w_strb;
        next_bvalid     = s_axi_bvalid && !s_axi_bready;
        next_bresp      = s_axi_bresp;
        next_rvalid     = s_axi_rvalid && !s_axi_rready;
        next_rdata      = s_axi_rdata;
        next_rresp      = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = is_mapped(aw_addr) ? tx_pcf_pkg::RESP_OKAY : tx_pcf_pkg::RESP_SLVERR;
            case ({aw_addr[4:2], 2'b00})
                tx_pcf_pkg::CTRL_OFS: begin
                    next_ctrl      = tx_pcf_pkg::ctrl_t'(merge_strb(ctrl, w_data, w_strb));
                    next_ctrl.rsvd = '0;
                end
                tx_pcf_pkg::STATUS_OFS: begin
                    ovf_clr = w_strb[0] && w_data[0];
                    udr_clr = w_strb[0] && w_data[1];
                end
                tx_pcf_pkg::DIV_OFS: begin
                    if (w_strb[0]) begin
                        next_div_ratio = w_data[tx_pcf_pkg::DIV_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = is_mapped(s_axi_araddr) ? tx_pcf_pkg::RESP_OKAY
                                                  : tx_pcf_pkg::RESP_SLVERR;
            case ({s_axi_araddr[4:2], 2'b00})
                tx_pcf_pkg::CTRL_OFS:   next_rdata = ctrl;
                tx_pcf_pkg::STATUS_OFS: next_rdata = status;
                tx_pcf_pkg::DIV_OFS:    next_rdata = {24'h000000, div_ratio};
                tx_pcf_pkg::COUNT_OFS:  next_rdata = word_count;
                default:                next_rdata = 32'h0000_0000;
            endcase
        end
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl          <= tx_pcf_pkg::ctrl_t'(tx_pcf_pkg::CTRL_RESET);
            div_ratio     <= tx_pcf_pkg::DIV_RESET;
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            w_held        <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= tx_pcf_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= tx_pcf_pkg::RESP_OKAY;
        end else begin
            ctrl          <= next_ctrl;
            div_ratio     <= next_div_ratio;
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    fifo_read_out_a: assert property (pop |=> pcs_valid && pcs_word == $past(fifo_out_data))
        else $error("popped word not presented");
    user_write_clk_a: assert property ((ctrl.enable && ctrl.user_wclk) |-> wr_tick == pin_edge[0])
        else $error("write tick not from user clock");
    overflow_seen_a: assert property (ovf_event |=> overflow_flag && !hold_valid)
        else $error("overflow not flagged");
    local_read_clk_a: assert property ((ctrl.enable && !ctrl.byte_ser && ctrl.bond == tx_pcf_pkg::BOND_NONE) |-> rd_tick == par_tick ##1 chan_par_clk_out == $past(next_par_tick))
        else $error("read tick not from local divider");
    byte_ser_half_a: assert property ((ctrl.enable && ctrl.byte_ser && sel_tick) |-> rd_tick == half ##1 half != $past(half))
        else $error("byte serializer divide wrong");
    x4_read_clk_a: assert property ((ctrl.enable && ctrl.bond == tx_pcf_pkg::BOND_X4 && !ctrl.byte_ser) |-> rd_tick == pin_edge[2] ##1 bonded_clk_out == $past(pin_edge[2]))
        else $error("four-lane read clock wrong");
    x8_read_clk_a: assert property ((ctrl.enable && ctrl.bond == tx_pcf_pkg::BOND_X8 && !ctrl.byte_ser) |-> rd_tick == pin_edge[3])
        else $error("eight-lane read clock wrong");
    group_write_clk_a: assert property ((ctrl.enable && !ctrl.user_wclk && ctrl.group_follow && ctrl.bond == tx_pcf_pkg::BOND_NONE) |-> wr_tick == pin_edge[1])
        else $error("write tick not from group lead");
    sticky_flags_a: assert property ((underrun_flag && !udr_clr) || udr_event |=> underrun_flag [*1] ##0 (overflow_flag || !$past(overflow_flag) || $past(ovf_clr)))
        else $error("sticky flag lost");

    user_clk_push_c: cover property (ctrl.user_wclk && push);
    x8_pop_c: cover property (ctrl.bond == tx_pcf_pkg::BOND_X8 && pop);
    overflow_c: cover property (ovf_event ##[1:20] overflow_flag && ovf_clr);

endmodule

// [verif/fabric_tx_src.sv]
// Purpose: Fabric transmit source that offers numbered words
// Assumes: Shares sys_clk with the FIFO write side
// Notes:   Holds each word until tx_ready takes it
module fabric_tx_src (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    // Transmit words
    input  wire logic            tx_ready,
    output tx_pcf_pkg::tx_word_t tx_word,
    output logic                 tx_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] seq;
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            seq      <= 32'h0;
            tx_valid <= 1'b0;
        end else begin
            tx_valid <= 1'b1;
            if (tx_valid && tx_ready) seq <= seq + 32'h1;
        end
    end
    assign tx_word = {seq[3:0], seq};
endmodule

// [verif/tx_phase_comp_fifo_write_clocking_test.sv]
// Purpose: Register, rate and clock source checks of the transmit FIFO
// Assumes: Pin clocks built from sys_clk counts
// Notes:   One row per clocking setup
module tx_phase_comp_fifo_write_clocking_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0, reset_n = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        tx_valid, tx_ready, pcs_valid, chan_par_clk_out, bonded_clk_out;
    logic        overflow_flag, underrun_flag, user_wclk = 1'b0, group_lead_clk = 1'b0;
    logic        cu0_local_clk = 1'b0, cu0_master_clk = 1'b0, ord_on = 1'b1;
    tx_pcf_pkg::tx_word_t tx_word, pcs_word;
    int err_total = 0, n_tests = 0, cyc = 0, fast = 0, exp_w = 0, n_pcs, n_chan, n_bond;
    // Columns: ctrl div fast pcs bonded over under
    int tbl [7][7] = '{'{3, 8, 0, 50, 0, 0, 0}, '{'h11, 8, 0, 50, 50, 0, 0},
        '{'h21, 8, 0, 40, 40, 0, 0}, '{7, 8, 0, 25, 0, 1, 0}, '{9, 16, 0, 25, 0, 1, 0},
        '{3, 8, 1, 50, 0, 1, 0}, '{3, 6, 0, -1, 0, 0, 1}};
    tx_phase_comp_fifo DUT (.*);
    fabric_tx_src src (.*);
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        cu0_local_clk <= cyc % 8 < 4;
        group_lead_clk <= cyc % 8 < 4;
        cu0_master_clk <= cyc % 10 < 5;
        user_wclk <= (fast != 0) ? cyc % 6 < 3 : cyc % 8 < 4;
    end
    always @(negedge sys_clk) begin
        if (pcs_valid && ord_on) chk("pcs_data", 32'(exp_w), pcs_word.data, 0);
        if (pcs_valid && ord_on) chk("pcs_ctrl", 32'(exp_w % 16), 32'(pcs_word.ctrl), 0);
        if (pcs_valid) exp_w++;
        if (pcs_valid) n_pcs++;
        if (chan_par_clk_out) n_chan++;
        if (bonded_clk_out) n_bond++;
    end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g, int tol);
        n_tests++;
        if (!(g === e || (tol > 0 && g + tol >= e && g <= e + tol))) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        bit da, dw;
        {da, dw} = 2'b00;
        @(posedge sys_clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(negedge sys_clk);
            da |= s_axi_awready;
            dw |= s_axi_wready;
            @(posedge sys_clk);
            if (da) s_axi_awvalid <= 1'b0;
            if (dw) s_axi_wvalid <= 1'b0;
        end while (!(da && dw));
        do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [4:0] a);
        @(posedge sys_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
        {rd, rs} = {s_axi_rdata, s_axi_rresp};
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask
    task automatic run(int i);
        int r [7];
        r = tbl[i];
        axw(tx_pcf_pkg::CTRL_OFS, 32'h0);
        axr(tx_pcf_pkg::COUNT_OFS);
        chk("word_count", 32'(exp_w), rd, 0);
        chk("tx_ready_off", 32'h0, {31'h0, tx_ready}, 0);
        axw(tx_pcf_pkg::STATUS_OFS, 32'h3);
        axr(tx_pcf_pkg::STATUS_OFS);
        chk("status_clear", 32'h0, {30'h0, rd[1:0]}, 0);
        fast = r[2];
        axw(tx_pcf_pkg::DIV_OFS, 32'(r[1]));
        axw(tx_pcf_pkg::CTRL_OFS, 32'(r[0]));
        repeat (100) @(posedge sys_clk);
        // Drop flags raised while settling
        axw(tx_pcf_pkg::STATUS_OFS, 32'h3);
        n_pcs = 0;
        n_chan = 0;
        n_bond = 0;
        repeat (400) @(posedge sys_clk);
        ord_on = 1'b0;
        if (r[3] >= 0) chk("pcs_count", 32'(r[3]), 32'(n_pcs), 2);
        chk("chan_clk", 32'(400 / r[1]), 32'(n_chan), 2);
        chk("bond_clk", 32'(r[4]), 32'(n_bond), 2);
        @(negedge sys_clk);
        chk("overflow", 32'(r[5]), {31'h0, overflow_flag}, 0);
        chk("underrun", 32'(r[6]), {31'h0, underrun_flag}, 0);
    endtask
    task automatic wrap_up;
        if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        axr(tx_pcf_pkg::CTRL_OFS);
        chk("ctrl_reset", tx_pcf_pkg::CTRL_RESET, rd, 0);
        axr(tx_pcf_pkg::DIV_OFS);
        chk("div_reset", 32'(tx_pcf_pkg::DIV_RESET), rd, 0);
        axr(5'h10);
        chk("unmapped_resp", 32'(tx_pcf_pkg::RESP_SLVERR), 32'(rs), 0);
        axw(5'h10, 32'hFFFF_FFFF);
        chk("unmapped_wresp", 32'(tx_pcf_pkg::RESP_SLVERR), 32'(rs), 0);
        for (int i = 0; i < 7; i++) run(i);
        wrap_up();
    end
    // Bound well past the expected run length
    initial begin
        #60000;
        err_total++;
        wrap_up();
    end
endmodule
